// >>> mode_zero_defines.svh
// Constants for the mode register zero block: field positions, codes and timing counts
// How it works
// - Register loads from address pins on set command with all strobes and banks low.
// - Auto-precharge delay after write is programmed recovery plus precharge period.
// - Bit three picks beat order, zero sequential, one interleaved.
// - Bits zero and one pick burst length; on-the-fly uses pin twelve per command.
// - Sequential reads wrap low two bits within nibble, then the other nibble.
// - Interleaved reads give beat k at start column xor k.
// - Chopped reads drive four beats, then hold data and strobe undriven.
// - Writes ignore low column bits; chop picks half by bit two; full writes in order.
// - Fixed four-beat writes start internally two clocks earlier than eight-beat.
// - On-the-fly chopped writes start internally at eight-beat time.
// - Bits two and four to six give column latency in whole clocks.
// - Total read latency is additive latency plus column latency.
// - Loop reset bit clears itself once the reset has been carried out.
// - Bit twelve picks slow or fast exit from precharge power-down.
`ifndef MODE_ZERO_DEFINES_SVH
`define MODE_ZERO_DEFINES_SVH
`define BL_LO 0
`define BT_BIT 3
`define CL_LO_BIT 2
`define CL_HI_LO 4
`define TEST_BIT 7
`define LOOP_RST_BIT 8
`define WR_LO 9
`define PD_EXIT_BIT 12
`define BL_CODE_EIGHT 2'h0
`define BL_CODE_OTF 2'h1
`define BL_CODE_CHOP 2'h2
`define PRECHARGE_PERIOD 5'h0b
`define FAST_EXIT_DELAY 5'h03
`define SLOW_EXIT_DELAY 5'h0a
`define CHOP_PULL_IN 5'h02
`define LOOP_RESET_CYCLES 4'h4
`endif

// >>> mode_zero_pkg.sv
// Types shared by the mode register zero block
package mode_zero_pkg;
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_wait = 4'h2,
        st_read = 4'h4,
        st_write = 4'h8
    } burst_state_type;
endpackage

// >>> beat_order.sv
// Column index of one beat in a read burst
`timescale 1ns/100ps
module beat_order
(
    input wire logic [2:0] start_col,
    input wire logic [2:0] beat,
    input wire logic interleaved,
    output logic [2:0] col
);
    // Interleave xors beat in; sequential wraps low two bits and flips nibble
    always_comb
    begin
        if (interleaved)
            col = start_col ^ beat;
        else
            col = {start_col[2] ^ beat[2], 2'(start_col[1:0] + beat[1:0])};
    end
endmodule

// >>> sdram_mode_zero_burst_order.sv
// Mode register zero, burst sequencing and latency timing seen from the device
`timescale 1ns/100ps
`include "mode_zero_defines.svh"
module sdram_mode_zero_burst_order
#(
    parameter int CL_TABLE_0 = 4,
    parameter int WR_TABLE_0 = 16
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ck_pin,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [2:0] bank,
    input wire logic [15:0] addr,
    input wire logic [4:0] additive_latency,
    output logic [15:0] mode_reg_zero,
    output logic mode_valid,
    output logic [3:0] column_read_latency,
    output logic [4:0] total_read_latency,
    output logic [4:0] recovery_cycles,
    output logic [4:0] autoprecharge_total_delay,
    output logic [4:0] power_down_exit_delay,
    output logic loop_reset_busy,
    output logic [2:0] read_col,
    output logic read_beat_valid,
    output logic dq_oe,
    output logic dqs_oe,
    output logic [2:0] write_col,
    output logic write_beat_valid,
    output logic [4:0] write_start_pull_in,
    output logic test_mode
);
    import mode_zero_pkg::*;

    //----------------------------------------
    // Synchronisers and link edge detection
    //----------------------------------------
    logic rst_meta, rst_sync;
    logic [24:0] in_meta, in_sync;
    logic ck_last;
    logic ck_rise;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // All pins pass two flops before use
    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            in_meta <= 25'h0;
            in_sync <= 25'h0;
            ck_last <= 1'b0;
        end
        else
        begin
            in_meta <= {ck_pin, cs_n, ras_n, cas_n, we_n, cke, bank, addr};
            in_sync <= in_meta;
            ck_last <= in_sync[24];
        end
    end

    assign ck_rise = in_sync[24] & ~ck_last;

    logic s_cs_n, s_ras_n, s_cas_n, s_we_n;
    logic [2:0] s_bank;
    logic [15:0] s_addr;
    logic cmd_mrs, cmd_read, cmd_write;
    assign s_cs_n = in_sync[23];
    assign s_ras_n = in_sync[22];
    assign s_cas_n = in_sync[21];
    assign s_we_n = in_sync[20];
    assign s_bank = in_sync[18:16];
    assign s_addr = in_sync[15:0];
    // Commands register on the link clock rising edge with clock enable high
    assign cmd_mrs = ck_rise & in_sync[19] & ~s_cs_n & ~s_ras_n & ~s_cas_n & ~s_we_n
                     & (s_bank == 3'h0);
    assign cmd_read = ck_rise & in_sync[19] & ~s_cs_n & s_ras_n & ~s_cas_n & s_we_n;
    assign cmd_write = ck_rise & in_sync[19] & ~s_cs_n & s_ras_n & ~s_cas_n & ~s_we_n;

    //----------------------------------------
    // Mode register and decoded fields
    //----------------------------------------
    logic [15:0] next_mode_reg_zero;
    logic next_mode_valid;
    logic [3:0] loop_count, next_loop_count;
    logic [3:0] cl_code;
    logic [2:0] wr_code;
    logic [3:0] cl_value;
    logic [4:0] wr_value;

    // Bit two is the top bit of the latency code, bits six to four the lower three
    assign cl_code = {mode_reg_zero[`CL_LO_BIT], mode_reg_zero[`CL_HI_LO +: 3]};
    assign wr_code = mode_reg_zero[`WR_LO +: 3];

    // Latency code table: codes 1..10 give 5..14 clocks, code 0 configurable
    always_comb
    begin
        if (cl_code == 4'h0)
            cl_value = 4'(CL_TABLE_0);
        else
            cl_value = 4'(cl_code + 4'h4);
    end

    // Recovery code table: 1..3 give 5..7, 4..7 give 8..14 even, 0 configurable
    always_comb
    begin
        if (wr_code == 3'h0)
            wr_value = 5'(WR_TABLE_0);
        else if (wr_code < 3'h4)
            wr_value = 5'({2'h0, wr_code} + 5'h4);
        else
            wr_value = 5'({wr_code, 1'b0});
    end

    // Load on set command; loop reset bit counts down then clears itself
    always_comb
    begin
        next_mode_reg_zero = mode_reg_zero;
        next_mode_valid = mode_valid;
        next_loop_count = loop_count;
        if (cmd_mrs)
        begin
            next_mode_reg_zero = s_addr;
            next_mode_valid = 1'b1;
            if (s_addr[`LOOP_RST_BIT])
                next_loop_count = `LOOP_RESET_CYCLES;
        end
        else if (loop_count != 4'h0)
        begin
            next_loop_count = 4'(loop_count - 4'h1);
            if (loop_count == 4'h1)
                next_mode_reg_zero[`LOOP_RST_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            mode_reg_zero <= 16'h0;
            mode_valid <= 1'b0;
            loop_count <= 4'h0;
        end
        else
        begin
            mode_reg_zero <= next_mode_reg_zero;
            mode_valid <= next_mode_valid;
            loop_count <= next_loop_count;
        end
    end

    // Registered timing outputs
    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            column_read_latency <= 4'h0;
            total_read_latency <= 5'h0;
            recovery_cycles <= 5'h0;
            autoprecharge_total_delay <= 5'h0;
            power_down_exit_delay <= 5'h0;
            loop_reset_busy <= 1'b0;
            test_mode <= 1'b0;
            write_start_pull_in <= 5'h0;
        end
        else
        begin
            column_read_latency <= cl_value;
            total_read_latency <= 5'({1'b0, cl_value} + additive_latency);
            recovery_cycles <= wr_value;
            autoprecharge_total_delay <= 5'(wr_value + `PRECHARGE_PERIOD);
            power_down_exit_delay <= mode_reg_zero[`PD_EXIT_BIT] ? `FAST_EXIT_DELAY
                                                                  : `SLOW_EXIT_DELAY;
            loop_reset_busy <= (loop_count != 4'h0);
            test_mode <= mode_reg_zero[`TEST_BIT];
            // Only fixed chop pulls the internal write in
            write_start_pull_in <= (mode_reg_zero[1:0] == `BL_CODE_CHOP) ? `CHOP_PULL_IN
                                                                          : 5'h0;
        end
    end

    //----------------------------------------
    // Burst sequencer
    //----------------------------------------
    burst_state_type state, next_state;
    logic [4:0] wait_count, next_wait_count;
    logic [2:0] beat, next_beat;
    logic [2:0] start_col, next_start_col;
    logic chop, next_chop;
    logic pending_write, next_pending_write;
    logic cmd_chop;
    logic [2:0] order_col;
    logic next_read_beat_valid, next_write_beat_valid, next_drive;
    logic [2:0] next_write_col;

    // Chop choice: fixed code or pin twelve when on the fly
    always_comb
    begin
        unique case (mode_reg_zero[1:0])
            `BL_CODE_CHOP: cmd_chop = 1'b1;
            `BL_CODE_OTF: cmd_chop = ~s_addr[12];
            default: cmd_chop = 1'b0;
        endcase
    end

    beat_order order_unit
    (
        .start_col(start_col),
        .beat(beat),
        .interleaved(mode_reg_zero[`BT_BIT]),
        .col(order_col)
    );

    // Beats advance one per link clock edge
    always_comb
    begin
        next_state = state;
        next_wait_count = wait_count;
        next_beat = beat;
        next_start_col = start_col;
        next_chop = chop;
        next_pending_write = pending_write;
        next_read_beat_valid = 1'b0;
        next_write_beat_valid = 1'b0;
        next_drive = 1'b0;
        next_write_col = write_col;
        unique case (state)
            st_idle:
            begin
                if (cmd_read | cmd_write)
                begin
                    next_chop = cmd_chop;
                    next_pending_write = cmd_write;
                    next_beat = 3'h0;
                    // Writes ignore low column bits
                    next_start_col = cmd_write ? {s_addr[2] & cmd_chop, 2'h0} : s_addr[2:0];
                    next_wait_count = total_read_latency;
                    next_state = st_wait;
                end
            end
            st_wait:
            begin
                if (ck_rise)
                begin
                    if (wait_count <= 5'h1)
                        next_state = pending_write ? st_write : st_read;
                    else
                        next_wait_count = 5'(wait_count - 5'h1);
                end
            end
            st_read:
            begin
                next_read_beat_valid = ~(chop & beat[2]);
                next_drive = ~(chop & beat[2]);
                if (ck_rise)
                begin
                    next_beat = 3'(beat + 3'h1);
                    if (beat == 3'h7)
                        next_state = st_idle;
                end
            end
            st_write:
            begin
                next_write_col = 3'(start_col + beat);
                next_write_beat_valid = ~(chop & beat[2]);
                if (ck_rise)
                begin
                    next_beat = 3'(beat + 3'h1);
                    if (beat == 3'h7)
                        next_state = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state <= st_idle;
            wait_count <= 5'h0;
            beat <= 3'h0;
            start_col <= 3'h0;
            chop <= 1'b0;
            pending_write <= 1'b0;
            read_col <= 3'h0;
            read_beat_valid <= 1'b0;
            dq_oe <= 1'b0;
            dqs_oe <= 1'b0;
            write_col <= 3'h0;
            write_beat_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            wait_count <= next_wait_count;
            beat <= next_beat;
            start_col <= next_start_col;
            chop <= next_chop;
            pending_write <= next_pending_write;
            read_col <= order_col;
            read_beat_valid <= next_read_beat_valid;
            dq_oe <= next_drive;
            dqs_oe <= next_drive;
            write_col <= next_write_col;
            write_beat_valid <= next_write_beat_valid;
        end
    end
endmodule

// >>> mode_zero_assertions.sv
// Concurrent checks on the mode register zero block
`timescale 1ns/100ps
`include "mode_zero_defines.svh"
module mode_zero_checker
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic mode_valid,
    input wire logic read_beat_valid,
    input wire logic write_beat_valid,
    input wire logic dq_oe,
    input wire logic dqs_oe,
    input wire logic [2:0] bank,
    input wire logic [3:0] column_read_latency,
    input wire logic [4:0] additive_latency,
    input wire logic [4:0] total_read_latency,
    input wire logic [4:0] recovery_cycles,
    input wire logic [4:0] autoprecharge_total_delay,
    input wire logic [4:0] power_down_exit_delay,
    input wire logic [4:0] write_start_pull_in,
    input wire logic [15:0] mode_reg_zero
);
    // ----------
    // Properties
    // ----------
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_load_on_set:
        assert property ($changed(mode_reg_zero) && !$fell(mode_reg_zero[8])
            |-> !cs_n && !ras_n && !cas_n && !we_n && cke && bank == 3'h0) else $error("load without set");
    a_latency_sum:
        assert property ((mode_valid && $stable(mode_reg_zero))[*2]
            |-> total_read_latency == 5'(column_read_latency) + additive_latency) else $error("bad read latency");
    a_autopre_sum:
        assert property ((mode_valid && $stable(mode_reg_zero))[*2]
            |-> autoprecharge_total_delay == recovery_cycles + `PRECHARGE_PERIOD) else $error("bad delay");
    a_exit_pick:
        assert property ((mode_valid && $stable(mode_reg_zero))[*2] |-> power_down_exit_delay
            == (mode_reg_zero[`PD_EXIT_BIT] ? `FAST_EXIT_DELAY : `SLOW_EXIT_DELAY)) else $error("bad exit");
    a_pull_in:
        assert property ((mode_valid && $stable(mode_reg_zero))[*2] |-> write_start_pull_in
            == (mode_reg_zero[1:0] == `BL_CODE_CHOP ? `CHOP_PULL_IN : 5'h00)) else $error("bad pull in");
    a_loop_clear:
        assert property ($rose(mode_reg_zero[8]) |-> ##[1:6] !mode_reg_zero[8]) else $error("loop bit stuck");
    a_quiet_drivers:
        assert property (!read_beat_valid |-> !dq_oe && !dqs_oe) else $error("driver on outside beat");
    a_no_early_beat:
        assert property (!mode_valid |-> !read_beat_valid && !write_beat_valid) else $error("beat before set");
endmodule
bind sdram_mode_zero_burst_order mode_zero_checker chk
(
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
    .mode_valid(mode_valid), .read_beat_valid(read_beat_valid), .write_beat_valid(write_beat_valid),
    .dq_oe(dq_oe), .dqs_oe(dqs_oe), .bank(bank), .column_read_latency(column_read_latency),
    .additive_latency(additive_latency), .total_read_latency(total_read_latency),
    .recovery_cycles(recovery_cycles), .autoprecharge_total_delay(autoprecharge_total_delay),
    .power_down_exit_delay(power_down_exit_delay), .write_start_pull_in(write_start_pull_in),
    .mode_reg_zero(mode_reg_zero)
);

// >>> ddr_ctl_model.sv
// Controller model driving the command pins and the link clock
`timescale 1ns/100ps
module ddr_ctl_model
(
    input wire logic mclk,
    output logic ck_pin,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic cke,
    output logic [2:0] bank,
    output logic [15:0] addr
);
    // Idle pins, link clock still
    initial
    begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        {ck_pin, cke, bank, addr} = {2'h1, 3'h0, 16'h0};
    end
    // One link period: pins move with the low phase and hold past the rising edge
    task automatic frame(input logic [3:0] cmd, input logic [2:0] ba, input logic [15:0] a, input logic ce);
        @(posedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= cmd;
        bank <= cmd[3] ? ~bank : ba; // Released pins wander
        addr <= cmd[3] ? ~addr : a & 16'h1fff;
        cke <= ce;
        ck_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        ck_pin <= 1'b1;
        repeat (7) @(posedge mclk);
    endtask
endmodule

// >>> sdram_mode_zero_burst_order_tb_top.sv
// Self-checking bench for the mode register zero block
`timescale 1ns/100ps
module sdram_mode_zero_burst_order_tb_top;
    localparam int AL = 3, CL_T0 = 4, WR_T0 = 16, RL = AL + 5, LOCK_FRAMES = 4, BUSY_CYC = 4;
    localparam logic [3:0] SET = 4'h0, RD = 4'h5, WRT = 4'h4, NOP = 4'hf;
    logic mclk, rst_n, ck_pin, cs_n, ras_n, cas_n, we_n, cke, mode_valid, loop_reset_busy;
    logic read_beat_valid, dq_oe, dqs_oe, write_beat_valid, test_mode;
    logic [2:0] bank, read_col, write_col;
    logic [3:0] column_read_latency;
    logic [4:0] additive_latency, total_read_latency, recovery_cycles, autoprecharge_total_delay;
    logic [4:0] power_down_exit_delay, write_start_pull_in;
    logic [15:0] addr, mode_reg_zero;
    int error_cnt = 0, n_checks = 0, busy_cycles = 0;
    ddr_ctl_model ctl (.mclk(mclk), .ck_pin(ck_pin), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .cke(cke), .bank(bank), .addr(addr));
    sdram_mode_zero_burst_order #(.CL_TABLE_0(CL_T0), .WR_TABLE_0(WR_T0)) DUT
    (
        .mclk(mclk), .rst_n(rst_n), .ck_pin(ck_pin), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .cke(cke), .bank(bank), .addr(addr), .additive_latency(additive_latency), .mode_reg_zero(mode_reg_zero),
        .mode_valid(mode_valid), .column_read_latency(column_read_latency), .total_read_latency(total_read_latency),
        .recovery_cycles(recovery_cycles), .autoprecharge_total_delay(autoprecharge_total_delay),
        .power_down_exit_delay(power_down_exit_delay), .loop_reset_busy(loop_reset_busy), .read_col(read_col),
        .read_beat_valid(read_beat_valid), .dq_oe(dq_oe), .dqs_oe(dqs_oe), .write_col(write_col),
        .write_beat_valid(write_beat_valid), .write_start_pull_in(write_start_pull_in), .test_mode(test_mode)
    );
    // -------------
    // Shared tasks
    // -------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Counts clocks with the loop reset running
    always @(posedge mclk)
        if (loop_reset_busy)
            busy_cycles <= busy_cycles + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic setm(input logic [15:0] v);
        ctl.frame(SET, 3'h0, v, 1'b1);
        repeat (2) ctl.frame(NOP, 3'h0, 16'h0, 1'b1);
        #1;
    endtask
    // Column of beat k: writes ignore low bits, reads wrap or flip
    function automatic logic [2:0] ecol(input logic wr, bt, chop, input logic [2:0] s, k);
        if (wr)
            return chop ? {s[2], k[1:0]} : k;
        if (bt)
            return s ^ k;
        return {s[2] ^ k[2], s[1:0] + k[1:0]};
    endfunction
    // ---------
    // Scenarios
    // ---------
    task automatic t_fields();
        logic [15:0] v;
        logic [3:0] c;
        logic [2:0] w;
        int cl;
        int r;
        for (int i = 0; i < 8; i++)
        begin
            w = 3'(i);
            c = (i == 0) ? 4'h0 : 4'(i + 3);
            cl = (c == 4'h0) ? CL_T0 : int'(c) + 4;
            r = (w == 3'h0) ? WR_T0 : (w < 3'h4 ? int'(w) + 4 : 2 * int'(w));
            v = {3'h0, w[1], w, 2'h0, c[2:0], w[0], c[3], w[1:0]};
            setm(v);
            chk(mode_reg_zero, v);
            chk(16'(column_read_latency), 16'(cl));
            chk(16'(total_read_latency), 16'(cl + AL));
            chk(16'(recovery_cycles), 16'(r));
            chk(16'(autoprecharge_total_delay), 16'(r + 11));
            chk(16'(power_down_exit_delay), w[1] ? 16'h3 : 16'ha);
            chk(16'(write_start_pull_in), w[1:0] == 2'h2 ? 16'h2 : 16'h0);
            chk({test_mode, mode_valid}, 16'h1);
            ctl.frame(SET, 3'h1, ~v, 1'b1);
            ctl.frame(SET, 3'h0, ~v, 1'b0);
            setm(16'h0);
            chk(mode_reg_zero, 16'h0);
        end
    endtask
    task automatic t_loop();
        int b0;
        b0 = busy_cycles;
        setm(16'h0310);
        chk(16'(busy_cycles - b0), 16'(BUSY_CYC));
        chk({mode_reg_zero[8], loop_reset_busy}, 16'h0);
        chk(mode_reg_zero, 16'h0210);
        repeat (LOCK_FRAMES) ctl.frame(NOP, 3'h0, 16'h0, 1'b1);
    endtask
    task automatic t_burst(input logic wr, input logic [1:0] bl, input logic bt, a12, input logic [2:0] s);
        logic chop;
        logic ev;
        int n;
        chop = bl == 2'h2 || (bl == 2'h1 && !a12);
        n = 0;
        setm(16'h0210 | {12'h0, bt, 1'b0, bl});
        ctl.frame(wr ? WRT : RD, 3'h0, {3'h0, a12, 9'h0, s}, 1'b1);
        for (int f = 1; f <= RL + 10; f++)
        begin
            ctl.frame(NOP, 3'h0, 16'h0, 1'b1);
            #1;
            ev = f >= RL && f < RL + (chop ? 4 : 8); // Beat k stands after link edge RL + k
            if (wr && write_beat_valid)
            begin
                chk(16'(write_col), 16'(ecol(1'b1, bt, chop, s, 3'(n))));
                n++;
            end
            if (!wr)
                chk({read_beat_valid, dq_oe, dqs_oe}, {13'h0, {3{ev}}});
            if (!wr && ev)
                chk(16'(read_col), 16'(ecol(1'b0, bt, chop, s, 3'(f - RL))));
        end
        if (wr)
            chk(16'(n), chop ? 16'h4 : 16'h8);
    endtask
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        additive_latency = 5'(AL);
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk({mode_valid, read_beat_valid, write_beat_valid}, 16'h0);
        t_fields();
        t_loop();
        for (int i = 0; i < 16; i++)
            t_burst(1'b0, 2'h0, i[3], 1'b0, 3'(i));
        t_burst(1'b0, 2'h2, 1'b0, 1'b1, 3'h5);
        t_burst(1'b0, 2'h1, 1'b1, 1'b0, 3'h3);
        t_burst(1'b0, 2'h1, 1'b0, 1'b1, 3'h6);
        t_burst(1'b1, 2'h0, 1'b0, 1'b0, 3'h5);
        t_burst(1'b1, 2'h2, 1'b0, 1'b0, 3'h6);
        t_burst(1'b1, 2'h1, 1'b1, 1'b0, 3'h1);
        t_burst(1'b1, 2'h1, 1'b0, 1'b1, 3'h3);
        end_of_test();
    end
    // Cuts a hang short
    initial
    begin
        #500000;
        error_cnt++;
        end_of_test();
    end
endmodule
